/* File: core/ubf_buffers.sv */
// receive buffer, transmit buffer/FIFO control and interrupt logic of the serial port
//
// Notes on behaviour
// - character into buffer sets receive ready
// - one buffer, main read clears, alias keeps
// - reset clears receive buffer contents
// - receive interrupt when its enable set
// - FIFO mode: bit 15 framing error
// - FIFO mode: bit 14 parity, 13-8 reserved
// - transmit upper unused bits ignored
// - transfer to shifter sets transmit ready
// - transmit interrupt when its enable set
// - soft reset bit stops both channels
// - FIFO mode enable, default off
// - transmit pointer reset, default released
// - transmit FIFO word count field
// - FIFO interrupt flag, write-one clear bit
// - FIFO interrupt when count at or below level
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module ubf_buffers
  import ubf_pkg::*;
#(
  parameter int TX_DEPTH = 16
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // register port
  input wire ubf_pkg::ubf_bus_req_s bus_req,
  output logic [15:0] bus_rdata,
  // receive shift register side
  input wire logic rx_char_valid,
  input wire ubf_pkg::ubf_rx_char_s rx_char,
  // transmit shift register side
  output logic tx_load_valid,
  input wire logic tx_load_ready,
  output logic [7:0] tx_load_data,
  input wire logic [2:0] char_len_code,
  // channel control and interrupt
  output logic channel_run,
  output logic irq
);
  import ubf_pkg::*;

  localparam int CNT_W = $clog2(TX_DEPTH) + 1;

  generate
    if (CNT_W != LVL_W) begin : g_bad_depth
      $error("ubf_buffers: transmit depth must fit the five-bit count field");
    end
  endgenerate

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic channel_soft_reset_n;
  logic fifo_mode_enable;
  logic tx_fifo_pointer_reset_n;
  logic tx_fifo_irq_enable;
  logic [LVL_W-1:0] tx_fifo_irq_level;
  logic tx_fifo_irq_flag;
  logic receive_break_irq_enable;
  logic transmit_irq_enable;
  logic receive_ready_flag;
  logic transmit_ready_flag;
  ubf_rx_char_s rx_data_buffer;
  logic [7:0] tx_data_buffer;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic wr_ctl2;
  logic wr_txbuf;
  logic wr_tfc;
  logic wr_irq_status;
  logic wr_irq_mask;
  logic rd_main;
  logic [7:0] char_mask;
  logic [7:0] tx_char_masked;
  logic fifo_clr;
  logic push_valid;
  logic push_ready;
  logic pop_valid;
  logic [CNT_W-1:0] tx_fifo_word_count;
  logic tx_transfer;
  logic rx_load;
  logic fifo_level_hit;
  logic [IRQ_W-1:0] irq_events;

  assign wr_ctl2 = bus_req.wr && (bus_req.addr == ADDR_CTL_TWO);
  assign wr_txbuf = bus_req.wr && (bus_req.addr == ADDR_TX_BUF);
  assign wr_tfc = bus_req.wr && (bus_req.addr == ADDR_TX_FIFO_CTL);
  assign wr_irq_status = bus_req.wr && (bus_req.addr == ADDR_IRQ_STATUS);
  assign wr_irq_mask = bus_req.wr && (bus_req.addr == ADDR_IRQ_MASK);
  assign rd_main = bus_req.rd && (bus_req.addr == ADDR_RX_BUF);

  assign channel_run = channel_soft_reset_n;

  // short characters: upper bits never reach the shifter
  assign char_mask = FULL_CHAR_MASK >> (MAX_LEN_CODE - char_len_code);
  assign tx_char_masked = bus_req.wdata[7:0] & char_mask;

  // ----------------------------------------------------------------
  // transmit path
  // ----------------------------------------------------------------
  // a stopped channel also flushes the store so no stale word goes out
  assign fifo_clr = !tx_fifo_pointer_reset_n || !channel_soft_reset_n;
  // without FIFO mode the store acts as the single transmit buffer
  assign push_valid = wr_txbuf && channel_soft_reset_n
                      && (fifo_mode_enable || tx_fifo_word_count == '0);
  assign tx_load_valid = pop_valid && channel_soft_reset_n;
  assign tx_transfer = tx_load_valid && tx_load_ready;

  ubf_tx_fifo #(
    .WIDTH(8),
    .DEPTH(TX_DEPTH),
    .CNT_W(CNT_W)
  ) u_tx_fifo (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .clr(fifo_clr),
    .wr_valid(push_valid),
    .wr_ready(push_ready),
    .wr_data(tx_char_masked),
    .rd_valid(pop_valid),
    .rd_ready(tx_load_ready && channel_soft_reset_n),
    .rd_data(tx_load_data),
    .count(tx_fifo_word_count)
  );

  always_ff @(posedge clk) begin
    if (!resetn) begin
      tx_data_buffer <= RST_CHAR;
    end else if (ce && push_valid && push_ready) begin
      tx_data_buffer <= tx_char_masked;
    end
  end

  // transfer to the shifter wins over a buffer write in the same cycle
  always_ff @(posedge clk) begin
    if (!resetn) begin
      transmit_ready_flag <= RST_TX_READY;
    end else if (ce) begin
      if (!channel_soft_reset_n) begin
        transmit_ready_flag <= RST_TX_READY;
      end else if (tx_transfer) begin
        transmit_ready_flag <= 1'b1;
      end else if (push_valid && push_ready) begin
        transmit_ready_flag <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // receive path
  // ----------------------------------------------------------------
  assign rx_load = rx_char_valid && channel_soft_reset_n;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      rx_data_buffer <= '0;
    end else if (ce && rx_load) begin
      rx_data_buffer <= rx_char;
    end
  end

  // a new character in the clearing-read cycle keeps the flag set
  always_ff @(posedge clk) begin
    if (!resetn) begin
      receive_ready_flag <= 1'b0;
    end else if (ce) begin
      if (!channel_soft_reset_n) begin
        receive_ready_flag <= 1'b0;
      end else if (rx_load) begin
        receive_ready_flag <= 1'b1;
      end else if (rd_main) begin
        receive_ready_flag <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  // soft reset leaves these configuration bits untouched
  always_ff @(posedge clk) begin
    if (!resetn) begin
      channel_soft_reset_n <= RST_CHANNEL_RUN;
      fifo_mode_enable <= RST_FIFO_ENA;
      tx_fifo_pointer_reset_n <= RST_PTR_RUN;
      tx_fifo_irq_enable <= 1'b0;
      tx_fifo_irq_level <= '0;
    end else if (ce && wr_tfc) begin
      channel_soft_reset_n <= bus_req.wdata[TFC_RST_BIT];
      fifo_mode_enable <= bus_req.wdata[TFC_ENA_BIT];
      tx_fifo_pointer_reset_n <= bus_req.wdata[TFC_PTR_RST_BIT];
      tx_fifo_irq_enable <= bus_req.wdata[TFC_IENA_BIT];
      tx_fifo_irq_level <= bus_req.wdata[TFC_LVL_LSB +: LVL_W];
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      receive_break_irq_enable <= 1'b0;
      transmit_irq_enable <= 1'b0;
    end else if (ce && wr_ctl2) begin
      receive_break_irq_enable <= bus_req.wdata[CTL2_RX_IRQ_EN_BIT];
      transmit_irq_enable <= bus_req.wdata[CTL2_TX_IRQ_EN_BIT];
    end
  end

  // ----------------------------------------------------------------
  // transmit FIFO level flag
  // ----------------------------------------------------------------
  assign fifo_level_hit = tx_fifo_irq_enable && fifo_mode_enable
                          && (tx_fifo_word_count <= tx_fifo_irq_level);

  // the level condition wins over a write-one clear in the same cycle
  always_ff @(posedge clk) begin
    if (!resetn) begin
      tx_fifo_irq_flag <= 1'b0;
    end else if (ce) begin
      if (fifo_level_hit) begin
        tx_fifo_irq_flag <= 1'b1;
      end else if (wr_tfc && bus_req.wdata[TFC_CLR_BIT]) begin
        tx_fifo_irq_flag <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt status, mask and output
  // ----------------------------------------------------------------
  assign irq_events[IRQ_RX_BIT] = rx_load && receive_break_irq_enable;
  assign irq_events[IRQ_TX_BIT] = tx_transfer && transmit_irq_enable;
  assign irq_events[IRQ_TXFIFO_BIT] = fifo_level_hit;

  // sticky bits, write one to clear, a new event wins
  always_ff @(posedge clk) begin
    if (!resetn) begin
      irq_status <= '0;
    end else if (ce) begin
      irq_status <= irq_events | (irq_status & ~({IRQ_W{wr_irq_status}} & bus_req.wdata[IRQ_W-1:0]));
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      irq_mask <= '0;
    end else if (ce && wr_irq_mask) begin
      irq_mask <= bus_req.wdata[IRQ_W-1:0];
    end
  end

  assign irq = |(irq_status & irq_mask);

  // ----------------------------------------------------------------
  // read data, one cycle after the strobe
  // ----------------------------------------------------------------
  logic [15:0] next_rdata;

  always_comb begin
    next_rdata = RST_WORD;
    unique case (bus_req.addr)
      ADDR_RX_PEEK: begin
        next_rdata[7:0] = rx_data_buffer.data;
      end
      ADDR_RX_BUF: begin
        next_rdata[7:0] = rx_data_buffer.data;
        next_rdata[RXB_FE_BIT] = fifo_mode_enable && rx_data_buffer.framing_err;
        next_rdata[RXB_PE_BIT] = fifo_mode_enable && rx_data_buffer.parity_err;
      end
      ADDR_RX_STATUS: begin
        next_rdata[RX_READY_BIT] = receive_ready_flag;
      end
      ADDR_CTL_TWO: begin
        next_rdata[CTL2_TX_READY_BIT] = transmit_ready_flag;
        next_rdata[CTL2_RX_IRQ_EN_BIT] = receive_break_irq_enable;
        next_rdata[CTL2_TX_IRQ_EN_BIT] = transmit_irq_enable;
      end
      ADDR_TX_BUF: begin
        next_rdata[7:0] = tx_data_buffer;
      end
      ADDR_TX_FIFO_CTL: begin
        next_rdata[TFC_RST_BIT] = channel_soft_reset_n;
        next_rdata[TFC_ENA_BIT] = fifo_mode_enable;
        next_rdata[TFC_PTR_RST_BIT] = tx_fifo_pointer_reset_n;
        next_rdata[TFC_CNT_LSB +: LVL_W] = tx_fifo_word_count;
        next_rdata[TFC_FLAG_BIT] = tx_fifo_irq_flag;
        next_rdata[TFC_IENA_BIT] = tx_fifo_irq_enable;
        next_rdata[TFC_LVL_LSB +: LVL_W] = tx_fifo_irq_level;
      end
      ADDR_IRQ_STATUS: begin
        next_rdata[IRQ_W-1:0] = irq_status;
      end
      ADDR_IRQ_MASK: begin
        next_rdata[IRQ_W-1:0] = irq_mask;
      end
      default: begin
        next_rdata = RST_WORD;
      end
    endcase
  end

  // data stands only in the cycle after the read strobe
  always_ff @(posedge clk) begin
    if (!resetn) begin
      bus_rdata <= RST_WORD;
    end else if (ce) begin
      bus_rdata <= bus_req.rd ? next_rdata : RST_WORD;
    end
  end
endmodule
`default_nettype wire

/* File: core/ubf_pkg.sv */
// package: register map, field positions and carriers of the serial port buffer block
package ubf_pkg;

  // ----------------------------------------------------------------
  // register addresses (word addresses on the register port)
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_CTL_TWO = 16'h7054;
  localparam logic [15:0] ADDR_RX_STATUS = 16'h7055;
  localparam logic [15:0] ADDR_RX_PEEK = 16'h7056;
  localparam logic [15:0] ADDR_RX_BUF = 16'h7057;
  localparam logic [15:0] ADDR_TX_BUF = 16'h7059;
  localparam logic [15:0] ADDR_TX_FIFO_CTL = 16'h705a;
  localparam logic [15:0] ADDR_IRQ_STATUS = 16'h7060;
  localparam logic [15:0] ADDR_IRQ_MASK = 16'h7061;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int RX_READY_BIT = 6;
  localparam int CTL2_TX_IRQ_EN_BIT = 0;
  localparam int CTL2_RX_IRQ_EN_BIT = 1;
  localparam int CTL2_TX_READY_BIT = 7;
  localparam int RXB_FE_BIT = 15;
  localparam int RXB_PE_BIT = 14;
  localparam int TFC_RST_BIT = 15;
  localparam int TFC_ENA_BIT = 14;
  localparam int TFC_PTR_RST_BIT = 13;
  localparam int TFC_CNT_LSB = 8;
  localparam int TFC_FLAG_BIT = 7;
  localparam int TFC_CLR_BIT = 6;
  localparam int TFC_IENA_BIT = 5;
  localparam int TFC_LVL_LSB = 0;
  localparam int LVL_W = 5;
  localparam int IRQ_W = 3;
  localparam int IRQ_RX_BIT = 0;
  localparam int IRQ_TX_BIT = 1;
  localparam int IRQ_TXFIFO_BIT = 2;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic RST_CHANNEL_RUN = 1'b1;
  localparam logic RST_FIFO_ENA = 1'b0;
  localparam logic RST_PTR_RUN = 1'b1;
  localparam logic RST_TX_READY = 1'b1;
  localparam logic [7:0] RST_CHAR = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [7:0] FULL_CHAR_MASK = 8'hff;
  localparam logic [2:0] MAX_LEN_CODE = 3'h7;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic framing_err;
    logic parity_err;
    logic [7:0] data;
  } ubf_rx_char_s;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } ubf_bus_req_s;

endpackage

/* File: core/ubf_tx_fifo.sv */
// transmit word store with count, clear and valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module ubf_tx_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int CNT_W = 5
) (
  // clock and control
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic clr,
  // fill side
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [WIDTH-1:0] wr_data,
  // drain side
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [WIDTH-1:0] rd_data,
  // fill level
  output logic [CNT_W-1:0] count
);
  localparam int PTR_W = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (1 << PTR_W) != DEPTH || CNT_W != PTR_W + 1) begin : g_bad
      $error("ubf_tx_fifo: depth must be a power of two and count one bit wider than the pointer");
    end
  endgenerate

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wptr;
  logic [PTR_W-1:0] rptr;
  logic push;
  logic pop;

  assign wr_ready = (count != CNT_W'(DEPTH));
  assign rd_valid = (count != '0);
  assign rd_data = mem[rptr];
  assign push = wr_valid && wr_ready;
  assign pop = rd_valid && rd_ready;

  always_ff @(posedge clk) begin
    if (ce && push) begin
      mem[wptr] <= wr_data;
    end
  end

  // pointers and count are held at zero while clr stands
  always_ff @(posedge clk) begin
    if (!resetn) begin
      wptr <= '0;
      rptr <= '0;
      count <= '0;
    end else if (ce) begin
      if (clr) begin
        wptr <= '0;
        rptr <= '0;
        count <= '0;
      end else begin
        if (push) begin
          wptr <= wptr + PTR_W'(1);
        end
        if (pop) begin
          rptr <= rptr + PTR_W'(1);
        end
        if (push && !pop) begin
          count <= count + CNT_W'(1);
        end else if (pop && !push) begin
          count <= count - CNT_W'(1);
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: test/tb_top.sv */
// testbench: directed scenarios for the serial port buffer block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ubf_pkg::*;
  // ----
  // signals and dut
  // ----
  logic clk;
  logic resetn;
  logic ce;
  ubf_bus_req_s req;
  logic [15:0] rdata;
  logic rxv;
  ubf_rx_char_s rxc;
  logic tv;
  logic trdy;
  logic [7:0] td;
  logic [2:0] len;
  logic run;
  logic irq;
  int n_fail;
  int tests_run;
  ubf_buffers #(.TX_DEPTH(16)) dut (
    .clk(clk), .resetn(resetn), .ce(ce), .bus_req(req), .bus_rdata(rdata),
    .rx_char_valid(rxv), .rx_char(rxc), .tx_load_valid(tv), .tx_load_ready(trdy),
    .tx_load_data(td), .char_len_code(len), .channel_run(run), .irq(irq));
  // ----
  // bus and compare tasks
  // ----
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    tests_run++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge clk);
    req.wr <= 1'b0;
  endtask
  // only the bits set in m are compared
  task automatic rd(input logic [15:0] a, input logic [15:0] m, input logic [15:0] e);
    @(posedge clk);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge clk);
    req.rd <= 1'b0;
    #1 chk(rdata & m, e);
  endtask
  task automatic rx(input logic fe, input logic pe, input logic [7:0] d);
    @(posedge clk);
    rxc <= '{fe, pe, d};
    rxv <= 1'b1;
    @(posedge clk);
    rxv <= 1'b0;
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_reset();
    rd(ADDR_RX_BUF, 16'hffff, 16'h0000);
    rd(ADDR_RX_PEEK, 16'hffff, 16'h0000);
    wr(ADDR_RX_BUF, 16'h1234);
    rd(ADDR_RX_BUF, 16'hffff, 16'h0000);
    rd(ADDR_TX_FIFO_CTL, 16'hffff, 16'ha000);
    rd(ADDR_CTL_TWO, 16'hffff, 16'h0080);
    rd(16'h7058, 16'hffff, 16'h0000);
    $display("reset test done");
  endtask
  task automatic t_rx();
    wr(ADDR_CTL_TWO, 16'h0002);
    wr(ADDR_IRQ_MASK, 16'h0007);
    rx(1'b1, 1'b1, 8'ha5);
    #1 chk(16'(irq), 16'h0001);
    rd(ADDR_RX_STATUS, 16'h0040, 16'h0040);
    rd(ADDR_RX_PEEK, 16'hffff, 16'h00a5);
    rd(ADDR_RX_STATUS, 16'h0040, 16'h0040);
    rd(ADDR_RX_BUF, 16'hffff, 16'h00a5);
    rd(ADDR_RX_STATUS, 16'h0040, 16'h0000);
    rd(ADDR_IRQ_STATUS, 16'h0007, 16'h0001);
    wr(ADDR_IRQ_MASK, 16'h0000);
    #1 chk(16'(irq), 16'h0000);
    wr(ADDR_IRQ_STATUS, 16'h0001);
    wr(ADDR_CTL_TWO, 16'h0000);
    rx(1'b0, 1'b0, 8'h11);
    rd(ADDR_IRQ_STATUS, 16'h0007, 16'h0000);
    wr(ADDR_IRQ_MASK, 16'h0007);
    $display("receive test done");
  endtask
  task automatic t_tx();
    wr(ADDR_CTL_TWO, 16'h0001);
    len <= 3'h4;
    wr(ADDR_TX_BUF, 16'h00ff);
    #1 chk(16'(td), 16'h001f);
    rd(ADDR_CTL_TWO, 16'h0080, 16'h0000);
    wr(ADDR_TX_BUF, 16'h0055);
    #1 chk(16'(td), 16'h001f);
    @(posedge clk);
    trdy <= 1'b1;
    @(posedge clk);
    trdy <= 1'b0;
    #1 chk(16'(tv), 16'h0000);
    rd(ADDR_CTL_TWO, 16'h0080, 16'h0080);
    rd(ADDR_IRQ_STATUS, 16'h0002, 16'h0002);
    #1 chk(16'(irq), 16'h0001);
    wr(ADDR_IRQ_STATUS, 16'h0007);
    len <= 3'h7;
    $display("transmit test done");
  endtask
  task automatic t_err();
    wr(ADDR_TX_FIFO_CTL, 16'he000);
    rx(1'b1, 1'b0, 8'h3c);
    rd(ADDR_RX_BUF, 16'hffff, 16'h803c);
    rx(1'b0, 1'b1, 8'hc3);
    rd(ADDR_RX_BUF, 16'hffff, 16'h40c3);
    $display("error bit test done");
  endtask
  task automatic t_fifo();
    int i;
    wr(ADDR_TX_FIFO_CTL, 16'he022);
    for (i = 0; i < 17; i++) begin
      wr(ADDR_TX_BUF, 16'(i));
    end
    rd(ADDR_TX_FIFO_CTL, 16'h1f00, 16'h1000);
    wr(ADDR_TX_FIFO_CTL, 16'he062);
    rd(ADDR_TX_FIFO_CTL, 16'h00c0, 16'h0000);
    @(posedge clk);
    trdy <= 1'b1;
    repeat (14) @(posedge clk);
    trdy <= 1'b0;
    #1 chk(16'(td), 16'h000e);
    rd(ADDR_TX_FIFO_CTL, 16'h1f80, 16'h0280);
    rd(ADDR_IRQ_STATUS, 16'h0004, 16'h0004);
    wr(ADDR_TX_FIFO_CTL, 16'hc022);
    rd(ADDR_TX_FIFO_CTL, 16'h1f00, 16'h0000);
    chk(16'(tv), 16'h0000);
    wr(ADDR_TX_FIFO_CTL, 16'he000);
    wr(ADDR_IRQ_STATUS, 16'h0007);
    $display("fifo test done");
  endtask
  task automatic t_soft();
    rx(1'b0, 1'b0, 8'h77);
    wr(ADDR_TX_FIFO_CTL, 16'h6020);
    #1 chk(16'(run), 16'h0000);
    rd(ADDR_RX_STATUS, 16'h0040, 16'h0000);
    rx(1'b0, 1'b0, 8'h99);
    rd(ADDR_RX_STATUS, 16'h0040, 16'h0000);
    wr(ADDR_TX_BUF, 16'h0011);
    #1 chk(16'(tv), 16'h0000);
    rd(ADDR_TX_FIFO_CTL, 16'he020, 16'h6020);
    wr(ADDR_TX_FIFO_CTL, 16'ha000);
    #1 chk(16'(run), 16'h0001);
    $display("soft reset test done");
  endtask
  // strobes with no gap; data is taken at the edge after it was launched
  task automatic t_b2b();
    wr(ADDR_TX_BUF, 16'h0042);
    trdy <= 1'b1;
    @(posedge clk);
    trdy <= 1'b0;
    req.addr <= ADDR_CTL_TWO;
    req.rd <= 1'b1;
    rxc <= '{1'b0, 1'b0, 8'h6b};
    rxv <= 1'b1;
    @(posedge clk);
    rxv <= 1'b0;
    req.addr <= ADDR_RX_STATUS;
    @(posedge clk);
    chk(rdata & 16'h0080, 16'h0080);
    req.addr <= ADDR_RX_PEEK;
    @(posedge clk);
    chk(rdata & 16'h0040, 16'h0040);
    req.addr <= ADDR_RX_BUF;
    @(posedge clk);
    chk(rdata, 16'h006b);
    req.addr <= ADDR_RX_STATUS;
    rxc <= '{1'b0, 1'b0, 8'h5a};
    rxv <= 1'b1;
    @(posedge clk);
    chk(rdata, 16'h006b);
    rxv <= 1'b0;
    req.addr <= ADDR_RX_BUF;
    @(posedge clk);
    chk(rdata & 16'h0040, 16'h0000);
    req.rd <= 1'b0;
    @(posedge clk);
    chk(rdata, 16'h005a);
    $display("back-to-back test done");
  endtask
  // ----
  // clock and main sequence
  // ----
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    n_fail = 0;
    tests_run = 0;
    resetn = 1'b0;
    ce = 1'b1;
    req = '0;
    rxv = 1'b0;
    rxc = '0;
    trdy = 1'b0;
    len = 3'h7;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_rx();
    t_tx();
    t_err();
    t_fifo();
    t_soft();
    t_b2b();
    tally_and_finish();
  end
endmodule
bind ubf_buffers ubf_buffers_props #(.TX_DEPTH(TX_DEPTH)) props (
  .clk(clk), .resetn(resetn), .ce(ce), .bus_req(bus_req), .bus_rdata(bus_rdata),
  .rx_char_valid(rx_char_valid), .rx_char(rx_char), .tx_load_valid(tx_load_valid),
  .tx_load_ready(tx_load_ready), .tx_load_data(tx_load_data), .char_len_code(char_len_code),
  .channel_run(channel_run), .irq(irq));
`default_nettype wire

/* File: test/ubf_buffers_props.sv */
// checker: port-level properties of the serial port buffer block
`timescale 1ns/1ps
`default_nettype none
module ubf_buffers_props
  import ubf_pkg::*;
#(
  parameter int TX_DEPTH = 16
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // register port
  input wire ubf_pkg::ubf_bus_req_s bus_req,
  input wire logic [15:0] bus_rdata,
  // shifter sides
  input wire logic rx_char_valid,
  input wire ubf_pkg::ubf_rx_char_s rx_char,
  input wire logic tx_load_valid,
  input wire logic tx_load_ready,
  input wire logic [7:0] tx_load_data,
  input wire logic [2:0] char_len_code,
  // status
  input wire logic channel_run,
  input wire logic irq
);
  logic [15:0] a;
  logic r;
  logic w;
  assign a = bus_req.addr;
  assign r = ce && bus_req.rd;
  assign w = ce && bus_req.wr;
  // a pointer reset flushes the head word, so the hold is owed only while the pointer runs
  logic ptr_run;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ptr_run <= 1'b1;
    end else if (w && a == ADDR_TX_FIFO_CTL) begin
      ptr_run <= bus_req.wdata[TFC_PTR_RST_BIT];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // ----
  // properties
  // ----
  rd_idle_a: assert property (ce && !bus_req.rd |=> bus_rdata == 16'h0000)
    else $error("read data not idle");
  peek_same_a: assert property (r && a == ADDR_RX_PEEK && !rx_char_valid
    ##1 r && a == ADDR_RX_BUF && !rx_char_valid |=> bus_rdata[7:0] == $past(bus_rdata[7:0]))
    else $error("alias and main differ");
  rx_data_a: assert property (rx_char_valid && ce && channel_run && !w
    ##1 r && a == ADDR_RX_BUF |=> bus_rdata[7:0] == $past(rx_char.data, 2))
    else $error("received byte lost");
  rx_ready_a: assert property (rx_char_valid && ce && channel_run && !w
    ##1 r && a == ADDR_RX_STATUS |=> bus_rdata[RX_READY_BIT])
    else $error("receive ready not set");
  rx_clear_a: assert property (r && a == ADDR_RX_BUF && !rx_char_valid
    ##1 r && a == ADDR_RX_STATUS |=> !bus_rdata[RX_READY_BIT])
    else $error("receive ready not cleared");
  tx_ready_a: assert property (tx_load_valid && tx_load_ready && ce
    ##1 r && a == ADDR_CTL_TWO |=> bus_rdata[CTL2_TX_READY_BIT])
    else $error("transmit ready not set");
  tx_mask_a: assert property ($rose(tx_load_valid) |->
    (tx_load_data >> ($past(char_len_code) + 4'd1)) == 8'h00)
    else $error("unused transmit bits kept");
  tx_hold_a: assert property (tx_load_valid && !tx_load_ready && ce && !w && ptr_run
    |=> tx_load_valid && $stable(tx_load_data))
    else $error("transmit word not held");
  run_off_a: assert property (!channel_run |-> !tx_load_valid)
    else $error("transmit while in reset");
  run_bit_a: assert property (w && a == ADDR_TX_FIFO_CTL
    |=> channel_run == $past(bus_req.wdata[TFC_RST_BIT]))
    else $error("run bit not followed");
  clr_zero_a: assert property ($past(r && a == ADDR_TX_FIFO_CTL) |-> !bus_rdata[TFC_CLR_BIT])
    else $error("clear bit reads one");
  cnt_max_a: assert property ($past(r && a == ADDR_TX_FIFO_CTL) |-> bus_rdata[12:8] <= TX_DEPTH)
    else $error("word count too large");
  rsv_zero_a: assert property ($past(r && a == ADDR_RX_BUF) |-> bus_rdata[13:8] == 6'h00)
    else $error("reserved bits set");
endmodule
`default_nettype wire
